/* common/tdp_map.svh */
`ifndef TDP_MAP_SVH
`define TDP_MAP_SVH

// Data path geometry
`define TDP_TRACKS 9
`define TDP_SKEW_DEPTH 4
`define TDP_SKEW_PTR_W 2
`define TDP_ACC_W 14

// Register byte offsets
`define TDP_OFF_CTRL 5'h00
`define TDP_OFF_GC 5'h04
`define TDP_OFF_CMD 5'h08
`define TDP_OFF_STAT 5'h0C
`define TDP_OFF_ERR_PAT 5'h10
`define TDP_OFF_CRC 5'h14

// Control register fields
`define TDP_CTRL_OP_LSB 0
`define TDP_CTRL_PE 3
`define TDP_CTRL_SEVEN 4
`define TDP_CTRL_EVEN 5
`define TDP_CTRL_PACK 6

// Command register fields
`define TDP_CMD_RELOAD 0
`define TDP_CMD_INJECT 1
`define TDP_CMD_CLEAR 2

// Reset values and constants
`define TDP_RST_GC 8'h01
`define TDP_RST_RELOAD 8'h01
`define TDP_CRC_MATCH 9'h1D7
`define TDP_CHAR_W 6
`define TDP_BYTE_W 8

`endif

/* common/tdp_pkg.sv */
package tdp_pkg;

`include "tdp_map.svh"

  typedef enum logic [2:0] {OP_IDLE, OP_STATUS, OP_SENSE, OP_WRITE, OP_READ} tdp_op_type;

  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } tdp_avs_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } tdp_avs_rsp_type;

  // Nine-bit tape byte, bit 8 is the parity track
  typedef struct packed {
    logic [8:0] data;
    logic valid;
  } tdp_byte_type;

  typedef struct packed {
    tdp_avs_rsp_type rsp;
    tdp_op_type op;
    logic pe;
    logic seven;
    logic even_red;
    logic pack;
    logic [7:0] gc;
    logic [7:0] reload;
    logic [7:0] bpc;
    logic half;
    tdp_byte_type io;
    tdp_byte_type a;
    tdp_byte_type b;
    tdp_byte_type ccr;
    tdp_byte_type bus_in;
    logic [8:0] wl;
    logic chk_pend;
    logic chk_odd;
    logic alt;
    logic [8:0] crc;
    logic [8:0] lrc;
    logic [8:0] dead;
    logic [7:0] err_pat;
    logic [8:0][3:0] skew;
    logic [8:0][1:0] wp;
    logic [1:0] rp;
    logic [8:0][2:0] cnt;
    logic [13:0] acc;
    logic [3:0] acnt;
    logic flush;
    logic wlp_err;
    logic path_err;
    logic skew_err;
  } tdp_state_type;

endpackage : tdp_pkg

/* logic/tdp_core.sv */
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module tdp_core (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input tdp_pkg::tdp_avs_req_type I_AVS_REQ,
  output tdp_pkg::tdp_avs_rsp_type O_AVS_RSP,
  input tdp_pkg::tdp_byte_type I_ABUS,
  output tdp_pkg::tdp_byte_type O_BUS_IN,
  input wire logic [8:0] I_TRACK_BIT,
  input wire logic [8:0] I_TRACK_STROBE,
  input wire logic I_PHASE_TIME,
  input wire logic I_RECORD_END,
  input wire logic I_BYTE_PARITY_ERR,
  output logic [8:0] O_WRITE_LEVEL
);
  import tdp_pkg::*;
`include "tdp_map.svh"

  function automatic logic odd9(input logic [8:0] v);
    odd9 = ^v;
  endfunction : odd9

  // Character with its parity track set for the chosen redundancy
  function automatic logic [8:0] char7(input logic [5:0] ch, input logic even);
    char7 = {2'b00, (^ch) ^ ~even, ch};
  endfunction : char7

  tdp_state_type s_reg;
  tdp_state_type s_next;
  logic [4:0] addr_w;
  logic [2:0] cmd;
  logic wr_mode;
  logic rd_mode;
  logic sense;
  logic nrzi;
  logic pk;
  logic tick;
  logic wr_tick;
  logic shift_tick;
  logic inject;
  logic pop;
  logic ccr_take;
  logic ccr_perr;
  logic load_b;
  logic [8:0] bval;
  logic [8:0] pop_byte;
  logic [8:0] ready;
  logic [8:0] corr;
  logic [8:0] push_ok;

  always_comb begin
    s_next = s_reg;
    addr_w = {I_AVS_REQ.address[4:2], 2'b00};
    cmd = 3'h0;
    wr_mode = (s_reg.op == OP_WRITE);
    rd_mode = (s_reg.op == OP_READ);
    sense = (s_reg.op == OP_SENSE);
    nrzi = !s_reg.pe;
    // Packing only with the 7-track feature and only once software selects it
    // mode gate
    pk = s_reg.pack && s_reg.seven;
    load_b = 1'b0;
    bval = 9'h000;
    pop_byte = 9'h000;
    ready = 9'h000;
    push_ok = 9'h000;

    // Bus slave: one wait cycle, act on the edge that sees waitrequest low
    s_next.rsp.waitrequest = 1'b1;
    if (I_AVS_REQ.read || I_AVS_REQ.write) begin
      if (s_reg.rsp.waitrequest) begin
        s_next.rsp.waitrequest = 1'b0;
        s_next.rsp.readdata = 32'h0000_0000;
        if (addr_w == `TDP_OFF_CTRL) begin
          s_next.rsp.readdata[6:0] = {s_reg.pack, s_reg.even_red, s_reg.seven, s_reg.pe,
                                      s_reg.op};
        end else if (addr_w == `TDP_OFF_GC) begin
          s_next.rsp.readdata[15:0] = {s_reg.reload, s_reg.gc};
        end else if (addr_w == `TDP_OFF_STAT) begin
          s_next.rsp.readdata[4:0] = {s_reg.crc == `TDP_CRC_MATCH, s_reg.skew_err,
                                      |s_reg.lrc, s_reg.path_err, s_reg.wlp_err};
          s_next.rsp.readdata[24:16] = s_reg.wl;
        end else if (addr_w == `TDP_OFF_ERR_PAT) begin
          s_next.rsp.readdata[7:0] = s_reg.err_pat;
          s_next.rsp.readdata[24:16] = s_reg.lrc;
        end else if (addr_w == `TDP_OFF_CRC) begin
          s_next.rsp.readdata[8:0] = s_reg.crc;
          s_next.rsp.readdata[24:16] = s_reg.dead;
        end
      end else if (I_AVS_REQ.write) begin
        if (addr_w == `TDP_OFF_CTRL) begin
          s_next.op = (I_AVS_REQ.writedata[2:0] > 3'h4) ? OP_IDLE
                      : tdp_op_type'(I_AVS_REQ.writedata[2:0]);
          s_next.pe = I_AVS_REQ.writedata[`TDP_CTRL_PE];
          s_next.seven = I_AVS_REQ.writedata[`TDP_CTRL_SEVEN];
          s_next.even_red = I_AVS_REQ.writedata[`TDP_CTRL_EVEN];
          s_next.pack = I_AVS_REQ.writedata[`TDP_CTRL_PACK];
        end else if (addr_w == `TDP_OFF_GC) begin
          s_next.gc = I_AVS_REQ.writedata[7:0];
        end else if (addr_w == `TDP_OFF_CMD) begin
          cmd = I_AVS_REQ.writedata[2:0];
        end
      end
    end
    if (cmd[`TDP_CMD_RELOAD]) begin
      s_next.reload = s_reg.gc;
    end
    // Clears come first so that a hardware set in the same cycle wins
    if (cmd[`TDP_CMD_CLEAR]) begin
      s_next.wlp_err = 1'b0;
      s_next.path_err = 1'b0;
      s_next.skew_err = 1'b0;
      s_next.lrc = 9'h000;
      s_next.crc = 9'h000;
      s_next.err_pat = 8'h00;
      s_next.alt = 1'b0;
    end

    tick = (s_reg.bpc == 8'h00);
    if (tick) begin
      s_next.bpc = s_reg.reload;
      s_next.half = ~s_reg.half;
    end else begin
      s_next.bpc = s_reg.bpc - 8'h01;
    end
    wr_tick = tick && !s_reg.half;
    shift_tick = tick && s_reg.half;

    s_next.chk_pend = 1'b0;
    if (wr_mode && wr_tick && s_reg.b.valid) begin
      s_next.b.valid = 1'b0;
      s_next.chk_pend = 1'b1;
      if (nrzi) begin
        s_next.wl = s_reg.wl ^ s_reg.b.data;
        s_next.chk_odd = (s_reg.seven && s_reg.even_red) ? 1'b0 : ~s_reg.alt;
        s_next.alt = ~s_reg.alt;
      end else begin
        s_next.wl = s_reg.b.data;
        s_next.chk_odd = 1'b1;
        s_next.alt = 1'b1;
      end
    end else if (wr_mode && shift_tick && s_reg.pe && s_reg.alt) begin
      s_next.wl = ~s_reg.wl;
      s_next.chk_odd = 1'b0;
      s_next.chk_pend = 1'b1;
      s_next.alt = 1'b0;
    end
    // even mode expects even count, caught through chk_odd low
    if (s_reg.chk_pend && (odd9(s_reg.wl) != s_reg.chk_odd)) begin
      s_next.wlp_err = 1'b1;
    end

    for (int i = 0; i < `TDP_TRACKS; i++) begin
      ready[i] = s_reg.dead[i] || (s_reg.cnt[i] != 3'h0);
      pop_byte[i] = !s_reg.dead[i] && s_reg.skew[i][s_reg.rp];
    end
    pop = (wr_mode || rd_mode) && (&ready) && !s_reg.ccr.valid && (~s_reg.dead != 9'h000);
    for (int i = 0; i < `TDP_TRACKS; i++) begin
      if (I_TRACK_STROBE[i] && !s_reg.dead[i] && (wr_mode || rd_mode)) begin
        if (s_reg.cnt[i] == 3'(`TDP_SKEW_DEPTH)) begin
          if (wr_mode) begin
            s_next.path_err = 1'b1;
          end else begin
            s_next.skew_err = 1'b1;
          end
        end else begin
          push_ok[i] = 1'b1;
          s_next.skew[i][s_reg.wp[i]] = I_TRACK_BIT[i];
          s_next.wp[i] = s_reg.wp[i] + 2'h1;
        end
      end
      s_next.cnt[i] = s_reg.cnt[i] + {2'b00, push_ok[i]} - {2'b00, pop && !s_reg.dead[i]};
    end
    if (pop) begin
      s_next.rp = s_reg.rp + 2'h1;
      s_next.ccr = {pop_byte, 1'b1};
    end

    ccr_perr = s_reg.ccr.valid && (odd9(s_reg.ccr.data) == (s_reg.seven && s_reg.even_red));
    corr = (ccr_perr && s_reg.pe) ? (s_reg.ccr.data ^ s_reg.dead) : s_reg.ccr.data;
    inject = cmd[`TDP_CMD_INJECT] && !s_reg.a.valid;
    ccr_take = s_reg.ccr.valid && (wr_mode || (rd_mode && !s_reg.a.valid && !inject));

    if (inject) begin
      s_next.a = {(sense ? s_reg.dead : s_reg.crc), 1'b1};
    end else if (ccr_take && rd_mode) begin
      s_next.a = {corr, 1'b1};
    end else if (wr_mode && s_reg.io.valid && !s_reg.a.valid) begin
      s_next.a = s_reg.io;
      s_next.io.valid = 1'b0;
    end
    if (ccr_take) begin
      s_next.ccr.valid = 1'b0;
      if (wr_mode) begin
        if (ccr_perr) begin
          s_next.path_err = 1'b1;
        end
      end else begin
        s_next.err_pat = {ccr_perr || I_BYTE_PARITY_ERR, s_reg.err_pat[7:1]};
        if (nrzi) begin
          s_next.lrc = s_reg.lrc ^ corr;
        end
      end
    end

    // stage one feeds stage two, through the packer when enabled
    if (!pk) begin
      if (s_reg.a.valid && !s_reg.b.valid) begin
        load_b = 1'b1;
        bval = s_reg.a.data;
        s_next.a.valid = 1'b0;
      end
    end else if (wr_mode) begin
      if (s_reg.acnt >= 4'd6 && !s_reg.b.valid) begin
        load_b = 1'b1;
        bval = char7(6'(s_reg.acc >> (s_reg.acnt - 4'd6)), s_reg.even_red);
        s_next.acnt = s_reg.acnt - 4'd6;
      end else if (s_reg.a.valid && s_reg.acnt < 4'd6) begin
        s_next.acc = {s_reg.acc[5:0], s_reg.a.data[7:0]};
        s_next.acnt = s_reg.acnt + 4'd8;
        s_next.a.valid = 1'b0;
      end else if (s_reg.flush && !s_reg.b.valid) begin
        s_next.flush = 1'b0;
        s_next.acnt = 4'd0;
        if (s_reg.acnt != 4'd0) begin
          load_b = 1'b1;
          bval = char7(6'(s_reg.acc << (4'd6 - s_reg.acnt)), s_reg.even_red);
        end
      end
    end else if (rd_mode) begin
      // four characters back to three bytes
      if (s_reg.acnt >= 4'd8 && !s_reg.b.valid) begin
        load_b = 1'b1;
        bval[7:0] = 8'(s_reg.acc >> (s_reg.acnt - 4'd8));
        bval[8] = ~^bval[7:0];
        s_next.acnt = s_reg.acnt - 4'd8;
      end else if (s_reg.a.valid && s_reg.acnt < 4'd8) begin
        s_next.acc = {s_reg.acc[7:0], s_reg.a.data[5:0]};
        s_next.acnt = s_reg.acnt + 4'd6;
        s_next.a.valid = 1'b0;
      end
    end else if (s_reg.a.valid && !s_reg.b.valid) begin
      load_b = 1'b1;
      bval = s_reg.a.data;
      s_next.a.valid = 1'b0;
    end
    if (load_b) begin
      s_next.b = {bval, 1'b1};
      if (nrzi && (wr_mode || rd_mode)) begin
        s_next.crc = {s_reg.crc[7:0], s_reg.crc[8]} ^ bval;
      end
    end

    // stage two to channel buffer on read or sense
    if ((rd_mode || sense) && s_reg.b.valid && !s_reg.io.valid) begin
      s_next.io = s_reg.b;
      s_next.b.valid = 1'b0;
      if (rd_mode && !pk && !odd9(s_reg.b.data)) begin
        s_next.path_err = 1'b1;
      end
    end else if ((s_reg.op == OP_STATUS || sense || wr_mode) && I_ABUS.valid
                 && !s_reg.io.valid) begin
      s_next.io = I_ABUS;
    end
    s_next.bus_in.valid = 1'b0;
    if (!wr_mode && s_reg.io.valid) begin
      s_next.bus_in = s_reg.io;
      s_next.io.valid = 1'b0;
    end

    // Record end clears dead tracks first so a phase-time set still wins
    if (I_RECORD_END) begin
      s_next.dead = 9'h000;
      s_next.wp = '0;
      s_next.rp = 2'h0;
      s_next.cnt = '0;
      s_next.ccr.valid = 1'b0;
      if (wr_mode) begin
        s_next.flush = 1'b1;
      end else begin
        s_next.acnt = 4'd0;
      end
    end
    if (s_reg.pe && rd_mode && I_PHASE_TIME) begin
      s_next.dead = s_next.dead | ~I_TRACK_STROBE;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      s_reg <= '0;
      s_reg.rsp.waitrequest <= 1'b1;
      s_reg.op <= OP_IDLE;
      s_reg.gc <= `TDP_RST_GC;
      s_reg.reload <= `TDP_RST_RELOAD;
    end else begin
      s_reg <= s_next;
    end
  end

  assign O_AVS_RSP = s_reg.rsp;
  assign O_BUS_IN = s_reg.bus_in;
  assign O_WRITE_LEVEL = s_reg.wl;

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);

  a_bus_answer: assert property (
    (I_AVS_REQ.read || I_AVS_REQ.write) && s_reg.rsp.waitrequest |=> !s_reg.rsp.waitrequest)
    else $error("bus request not answered after one wait cycle");
  a_nrzi_toggle: assert property (
    wr_mode && nrzi && wr_tick && s_reg.b.valid
    |=> s_reg.wl == ($past(s_reg.wl) ^ $past(s_reg.b.data)))
    else $error("nrzi write levels did not toggle on ones");
  a_pe_shift: assert property (
    wr_mode && s_reg.pe && shift_tick && s_reg.alt && !(wr_tick && s_reg.b.valid)
    |=> s_reg.wl == ~$past(s_reg.wl))
    else $error("pe write levels not inverted at bit shift");
  a_wl_parity: assert property (
    s_reg.chk_pend && (odd9(s_reg.wl) != s_reg.chk_odd) |=> s_reg.wlp_err)
    else $error("write level parity error not flagged");
  a_pattern_mark: assert property (
    ccr_take && rd_mode && I_BYTE_PARITY_ERR |=> s_reg.err_pat[7])
    else $error("error pattern bit 7 not set");
  a_dead_latch: assert property (
    s_reg.pe && rd_mode && I_PHASE_TIME |=> ((~$past(I_TRACK_STROBE)) & ~s_reg.dead) == 9'h000)
    else $error("silent track not marked dead");
  a_path_read: assert property (
    rd_mode && !pk && s_reg.b.valid && !s_reg.io.valid && !odd9(s_reg.b.data) |=> s_reg.path_err)
    else $error("read data error did not set path latch");
  a_lrc_fold: assert property (
    ccr_take && rd_mode && nrzi && !cmd[`TDP_CMD_CLEAR]
    |=> s_reg.lrc == ($past(s_reg.lrc) ^ $past(corr)))
    else $error("longitudinal check not accumulated");
  a_bpc_reload: assert property (
    s_reg.bpc == 8'h00 |=> s_reg.bpc == $past(s_reg.reload) && s_reg.half != $past(s_reg.half))
    else $error("bit period counter did not reload at zero");
  a_pop_ready: assert property (
    pop && !I_RECORD_END |=> s_reg.ccr.valid && s_reg.rp == $past(s_reg.rp) + 2'h1)
    else $error("byte removed from skew buffers incorrectly");

endmodule : tdp_core

/* verification/tdp_tape_model.sv */
`timescale 1ns/1ps
module tdp_tape_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic [8:0] i_byte,
  output logic [8:0] o_track_bit,
  output logic [8:0] o_track_strobe
);
  logic [8:0] data_reg;
  logic [1:0] cnt_reg;
  logic busy_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_reg <= 1'b0;
      cnt_reg <= 2'h0;
      data_reg <= 9'h000;
    end else if (i_go) begin
      busy_reg <= 1'b1;
      cnt_reg <= 2'h0;
      data_reg <= i_byte;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg + 2'h1;
      if (cnt_reg == 2'h2) begin
        busy_reg <= 1'b0;
      end
    end
  end
  // Tracks arrive up to two cycles apart, so skew alignment is really exercised
  always_comb begin
    for (int t = 0; t < 9; t++) begin
      o_track_strobe[t] = busy_reg && (cnt_reg == 2'(t % 3));
      // Off-strobe the line shows the inverse so a stale sample never looks right
      o_track_bit[t] = o_track_strobe[t] ? data_reg[t] : ~data_reg[t];
    end
  end
endmodule : tdp_tape_model

/* verification/tdp_core_tb.sv */
`timescale 1ns/1ps
module tdp_core_tb;
  import tdp_pkg::*;
  typedef struct packed {
    logic [2:0] op;
    logic [8:0] d;
  } tdp_row_type;
  logic clk, rst, phase, rend, perr, go;
  tdp_avs_req_type req;
  tdp_avs_rsp_type rsp;
  tdp_byte_type abus, bus_in;
  logic [8:0] tbit, tstb, wl, mbyte, p;
  logic [31:0] q;
  int n_fail, checks_done, cyc, n;
  tdp_row_type rows [4] = '{'{3'h1, 9'h1A5}, '{3'h2, 9'h000}, '{3'h1, 9'h1FF}, '{3'h2, 9'h05A}};

  tdp_core tdp_core_i (.I_REF_CLK(clk), .I_RST(rst), .I_AVS_REQ(req), .O_AVS_RSP(rsp),
    .I_ABUS(abus), .O_BUS_IN(bus_in), .I_TRACK_BIT(tbit), .I_TRACK_STROBE(tstb),
    .I_PHASE_TIME(phase), .I_RECORD_END(rend), .I_BYTE_PARITY_ERR(perr), .O_WRITE_LEVEL(wl));
  tdp_tape_model tdp_tape_model_i (.i_clk(clk), .i_rst(rst), .i_go(go), .i_byte(mbyte),
    .o_track_bit(tbit), .o_track_strobe(tstb));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // Ceiling sits far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  // Request stands until the rising edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{address: a, read: !wr, write: wr, writedata: d};
    do @(posedge clk); while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req <= '0;
  endtask : bus

  task automatic rdm(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rdm

  task automatic put(input logic [8:0] b);
    @(posedge clk);
    abus <= '{data: b, valid: 1'b1};
    @(posedge clk);
    abus <= '0;
  endtask : put

  task automatic getout(input logic [8:0] e);
    n = 0;
    while (bus_in.valid !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk({23'h0, bus_in.data}, {23'h0, e});
    chk({31'h0, bus_in.valid}, 32'h1);
  endtask : getout

  task automatic wchg;
    logic [8:0] s;
    s = wl;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (wl === s && n < 60);
  endtask : wchg

  task automatic wbyte(input logic [8:0] b, input logic [8:0] dlt);
    p = wl;
    put(b);
    wchg();
    chk({23'h0, wl}, {23'h0, p ^ dlt});
    repeat (4) @(posedge clk);
  endtask : wbyte

  task automatic tape(input logic [8:0] b);
    @(posedge clk);
    mbyte <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : tape

  task automatic do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdm(5'h04, 32'hFFFFFFFF, 32'h00000101);
    rdm(5'h0C, 32'hFFFFFFFF, 32'h0);
    chk({23'h0, wl}, 32'h0);
    $display("test reset done");
  endtask : do_reset

  initial begin
    rst = 1'b1;
    req = '0;
    abus = '0;
    phase = 1'b0;
    rend = 1'b0;
    perr = 1'b0;
    go = 1'b0;
    mbyte = 9'h000;
    do_reset();
    bus(1'b1, 5'h18, 32'hFFFFFFFF);
    rdm(5'h18, 32'hFFFFFFFF, 32'h0);
    $display("test unmapped done");
    foreach (rows[i]) begin
      bus(1'b1, 5'h00, {29'h0, rows[i].op});
      put(rows[i].d);
      getout(rows[i].d);
    end
    $display("test status sense done");
    bus(1'b1, 5'h04, 32'h0);
    bus(1'b1, 5'h08, 32'h1);
    rdm(5'h04, 32'h0000FFFF, 32'h0);
    bus(1'b1, 5'h08, 32'h4);
    bus(1'b1, 5'h00, 32'h3);
    wbyte(9'h1A5, 9'h1A5);
    wbyte(9'h001, 9'h001);
    wbyte(9'h1FF, 9'h1FF);
    rdm(5'h0C, 32'h1, 32'h0);
    wbyte(9'h003, 9'h003);
    rdm(5'h0C, 32'h1, 32'h1);
    rdm(5'h0C, 32'h01FF0000, 32'h00580000);
    rdm(5'h14, 32'h000001FF, 32'h000000D6);
    $display("test nrzi write done");
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b1, 5'h08, 32'h4);
    bus(1'b1, 5'h00, 32'h53);
    wbyte(9'h0A5, 9'h029);
    p = wl;
    @(posedge clk);
    rend <= 1'b1;
    @(posedge clk);
    rend <= 1'b0;
    wchg();
    chk({23'h0, wl}, {23'h0, p ^ 9'h010});
    $display("test packing done");
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b1, 5'h04, 32'h3);
    bus(1'b1, 5'h08, 32'h1);
    rdm(5'h04, 32'h0000FFFF, 32'h0303);
    bus(1'b1, 5'h08, 32'h4);
    bus(1'b1, 5'h00, 32'h0B);
    put(9'h1A5);
    wchg();
    chk({23'h0, wl}, 32'h1A5);
    wchg();
    chk(n, 32'h4);
    chk({23'h0, wl}, 32'h05A);
    rdm(5'h0C, 32'h1, 32'h0);
    $display("test pe write done");
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b1, 5'h08, 32'h4);
    bus(1'b1, 5'h00, 32'h4);
    tape(9'h1A5);
    getout(9'h1A5);
    rdm(5'h0C, 32'h7, 32'h4);
    @(posedge clk);
    perr <= 1'b1;
    tape(9'h0A5);
    getout(9'h0A5);
    @(posedge clk);
    perr <= 1'b0;
    rdm(5'h0C, 32'h2, 32'h2);
    rdm(5'h10, 32'h01FF0000, 32'h01000000);
    chk({24'h0, q[7:0]}, 32'h80);
    bus(1'b1, 5'h08, 32'h4);
    rdm(5'h0C, 32'h7, 32'h0);
    $display("test read done");
    bus(1'b1, 5'h00, 32'h0C);
    tape(9'h009);
    phase <= 1'b1;
    @(posedge clk);
    phase <= 1'b0;
    getout(9'h1BF);
    rdm(5'h14, 32'h01FF0000, 32'h01B60000);
    bus(1'b1, 5'h00, 32'h2);
    bus(1'b1, 5'h08, 32'h2);
    getout(9'h1B6);
    @(posedge clk);
    rend <= 1'b1;
    @(posedge clk);
    rend <= 1'b0;
    rdm(5'h14, 32'h01FF0000, 32'h0);
    $display("test dead track done");
    do_reset();
    bus(1'b1, 5'h00, 32'h33);
    wbyte(9'h003, 9'h003);
    rdm(5'h0C, 32'h1, 32'h0);
    wbyte(9'h001, 9'h001);
    rdm(5'h0C, 32'h1, 32'h1);
    $display("test even mode done");
    results();
  end
endmodule : tdp_core_tb
